// File: hw/rcd_decoder.sv
// Purpose: serial 12-bit remote code word decoder
// Assumes: serial input and address straps come from pins
// Notes: bit waveform is pulse-width coded, position 0 sent first
module rcd_decoder
  import rcd_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_BITS_LATCH,
  parameter logic [CNT_W-1:0] BIT_THRESH = CNT_W'(BIT_THRESH_CYC),
  parameter logic [CNT_W-1:0] GAP_LEN = CNT_W'(GAP_CYC),
  parameter logic [CNT_W-1:0] STOP_LEN = CNT_W'(STOP_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial input and address straps
  input wire logic serial_in,
  input wire logic [WORD_BITS-1:0] local_address_pins,
  // decoded outputs
  output logic valid_transmission,
  output logic [DATA_BITS-1:0] latched_data_outputs,
  output logic osc_active
);

  // ---------------------------------------------------------------
  // address compare over the first n positions
  // ---------------------------------------------------------------
  function automatic logic addr_equal(
    input logic [WORD_BITS-1:0] word,
    input logic [WORD_BITS-1:0] addr
  );
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < WORD_BITS; i++)
    begin
      if (i < ADDR_BITS && word[i] != addr[i])
      begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction : addr_equal

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [WORD_BITS:0] pins_s;
  logic din_s;
  logic [WORD_BITS-1:0] addr_s;

  // straps are static, so a plain two-flop pass is enough
  rcd_sync #(.WIDTH(WORD_BITS + 1)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({serial_in, local_address_pins}),
    .sync_out(pins_s)
  );

  assign din_s = pins_s[WORD_BITS];
  assign addr_s = pins_s[WORD_BITS-1:0];

  // ---------------------------------------------------------------
  // decoder state
  // ---------------------------------------------------------------
  rcd_regs_t q;
  rcd_regs_t d;
  logic [WORD_BITS-1:0] word_n;
  logic word_done;
  logic word_ok;
  logic accept;
  logic abort;
  logic [3:0] bits_n;

  always_comb
  begin
    d = q;
    word_done = 1'b0;
    word_ok = 1'b0;
    accept = 1'b0;
    abort = 1'b0;
    bits_n = q.bits + 4'h1;
    word_n = {din_s, q.shift[WORD_BITS-1:1]};
    unique case (q.state)
      RCD_IDLE:
      begin
        d.active = 1'b0;
        d.cnt = '0;
        if (din_s)
        begin
          d.state = RCD_HIGH;
          d.active = 1'b1;
        end
      end
      RCD_HIGH:
      begin
        if (q.cnt != STOP_LEN)
        begin
          d.cnt = q.cnt + CNT_W'(1);
        end
        if (!din_s)
        begin
          // long high reads as one; position 0 ends up in bit 0
          word_n = {(q.cnt >= BIT_THRESH), q.shift[WORD_BITS-1:1]};
          d.shift = word_n;
          d.state = RCD_LOW;
          d.cnt = '0;
          d.bits = bits_n;
          if (bits_n == BITS_PER_WORD)
          begin
            d.bits = 4'h0;
            word_done = 1'b1;
          end
        end
      end
      RCD_LOW:
      begin
        if (q.cnt != STOP_LEN)
        begin
          d.cnt = q.cnt + CNT_W'(1);
        end
        if (din_s)
        begin
          d.state = RCD_HIGH;
          d.cnt = '0;
        end
        else if (q.cnt == STOP_LEN)
        begin
          // silence: reception stopped, back to standby
          d.state = RCD_IDLE;
          d.active = 1'b0;
          d.valid = 1'b0;
          d.match = 2'h0;
          d.bits = 4'h0;
        end
        else if (q.cnt == GAP_LEN && q.bits != 4'h0)
        begin
          // broken word: resync and treat as an error
          abort = 1'b1;
          d.bits = 4'h0;
          d.match = 2'h0;
          d.valid = 1'b0;
        end
      end
      default:
      begin
        d.state = RCD_IDLE;
      end
    endcase
    if (word_done)
    begin
      word_ok = addr_equal(word_n, addr_s);
      if (!word_ok)
      begin
        d.match = 2'h0;
        d.valid = 1'b0;
      end
      else if (q.match == MATCH_LAST)
      begin
        accept = 1'b1;
        d.valid = 1'b1;
        if (ADDR_BITS == ADDR_BITS_LATCH)
        begin
          d.data = word_n[WORD_BITS-1:ADDR_BITS_LATCH];
        end
      end
      else
      begin
        d.match = q.match + 2'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q <= '{state: RCD_IDLE, cnt: '0, bits: 4'h0, shift: '0,
             match: 2'h0, valid: 1'b0, data: DATA_RESET, active: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign valid_transmission = q.valid;
  assign latched_data_outputs = q.data;
  assign osc_active = q.active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  build_variant_a: assert property (ADDR_BITS == ADDR_BITS_LATCH ||
      ADDR_BITS == ADDR_BITS_ADDR_ONLY)
    else $error("unsupported address width");
  idle_valid_low_a: assert property (q.state == RCD_IDLE |-> !q.valid)
    else $error("valid high in standby");
  three_checks_a: assert property ($rose(q.valid) |->
      $past(q.match) == MATCH_LAST)
    else $error("valid raised before three matches");
  mismatch_drop_a: assert property (word_done && !word_ok |=>
      !q.valid && q.match == 2'h0)
    else $error("valid kept after mismatch");
  data_load_a: assert property (accept && ADDR_BITS == ADDR_BITS_LATCH |=>
      q.data == $past(word_n[WORD_BITS-1:ADDR_BITS_LATCH]) && q.valid)
    else $error("data not loaded on accept");
  data_hold_a: assert property (!accept |=> $stable(q.data))
    else $error("data changed without valid word");
  no_data_out_a: assert property (ADDR_BITS != ADDR_BITS_ADDR_ONLY ||
      q.data == DATA_RESET)
    else $error("data driven in address-only build");
  osc_start_a: assert property (q.state == RCD_IDLE && din_s |=>
      q.active && q.state == RCD_HIGH)
    else $error("decoder did not wake on high");
  silence_stop_a: assert property (q.state == RCD_LOW && !din_s &&
      q.cnt == STOP_LEN |=> q.state == RCD_IDLE && !q.valid)
    else $error("no standby after silence");
  word_length_a: assert property (word_done |-> $past(q.bits) ==
      BITS_PER_WORD - 4'h1 || q.bits == 4'h0)
    else $error("word closed at wrong length");

  accept_c: cover property (accept);
  abort_c: cover property (abort ##[1:1000] accept);
  stop_c: cover property (q.valid ##1 !q.valid && q.state == RCD_IDLE);

endmodule : rcd_decoder

// File: hw/rcd_pkg.sv
// Purpose: constants and types shared by the remote code decoder
// Assumes: 50 MHz system clock
// Notes: serial bit times are board choices, kept here as named figures
package rcd_pkg;

  // ---------------------------------------------------------------
  // clock and word layout
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int WORD_BITS = 12;
  localparam int DATA_BITS = 4;
  localparam int ADDR_BITS_LATCH = 8;
  localparam int ADDR_BITS_ADDR_ONLY = 12;
  localparam int CHECK_COUNT = 3;
  localparam int CNT_W = 20;
  localparam logic [3:0] BITS_PER_WORD = 4'hc;
  localparam logic [1:0] MATCH_LAST = 2'h2;
  localparam logic [DATA_BITS-1:0] DATA_RESET = 4'h0;

  // ---------------------------------------------------------------
  // serial timing
  // ---------------------------------------------------------------
  // high pulse at least this long reads as a one
  localparam int BIT_THRESH_US = 200;
  // low time this long inside an unfinished word drops that partial word
  localparam int GAP_US = 1000;
  // low time this long means reception has stopped
  localparam int STOP_US = 20000;
  localparam int BIT_THRESH_CYC = BIT_THRESH_US * CYC_PER_US;
  localparam int GAP_CYC = GAP_US * CYC_PER_US;
  localparam int STOP_CYC = STOP_US * CYC_PER_US;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCD_IDLE = 2'h0,
    RCD_HIGH = 2'h1,
    RCD_LOW = 2'h2
  } rcd_state_t;

  typedef struct packed {
    rcd_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bits;
    logic [WORD_BITS-1:0] shift;
    logic [1:0] match;
    logic valid;
    logic [DATA_BITS-1:0] data;
    logic active;
  } rcd_regs_t;

endpackage : rcd_pkg

// File: hw/rcd_sync.sv
// Purpose: two-flop synchroniser for the decoder pins
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second stage
module rcd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  // synchronised
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : rcd_sync

// File: sim/rcd_encoder.sv
// Purpose: behavioural model of the paired remote encoder
// Assumes: long high pulse is a one, position 0 sent first
// Notes: line rests low between words, gap is chosen per call
module rcd_encoder (
  // clock
  input wire logic clk,
  // serial line
  output logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial serial_out = 1'b0;

  // -------------------------------------------------------------
  // one word, gap in cycles after the last bit's four low cycles
  // -------------------------------------------------------------
  task automatic send_word(input logic [11:0] word, input int gap);
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk) serial_out = 1'b1;
      repeat (word[i] ? 8 : 2) @(negedge clk);
      serial_out = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (gap) @(negedge clk);
  endtask : send_word
endmodule : rcd_encoder

// File: sim/remote_code_decoder_test.sv
// Purpose: self-checking bench for the remote code decoder
// Assumes: shortened bit and stop counts, gap left at its default
// Notes: one build of each width shares the serial line and straps
module remote_code_decoder_test;
  import rcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic serial_in;
  logic [WORD_BITS-1:0] addr_pins = 12'h5a3;
  logic vt8, vt12, osc8, osc12;
  logic [DATA_BITS-1:0] data8, data12;
  int miscompares = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  // -------------------------------------------------------------
  // design builds and encoder
  // -------------------------------------------------------------
  rcd_encoder enc (.clk(clk), .serial_out(serial_in));
  // stop shortened below the default gap: only silence ends a partial word
  rcd_decoder #(.BIT_THRESH(20'h4),
    .STOP_LEN(20'hc8)) dut (.clk(clk), .reset_n(reset_n),
    .serial_in(serial_in), .local_address_pins(addr_pins),
    .valid_transmission(vt8), .latched_data_outputs(data8),
    .osc_active(osc8));
  rcd_decoder #(.ADDR_BITS(12), .BIT_THRESH(20'h4),
    .STOP_LEN(20'hc8)) dut_wide (.clk(clk), .reset_n(reset_n),
    .serial_in(serial_in), .local_address_pins(addr_pins),
    .valid_transmission(vt12), .latched_data_outputs(data12),
    .osc_active(osc12));

  // -------------------------------------------------------------
  // checking helpers
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic outs(input logic v8, input logic [3:0] d8,
    input logic v12);
    check("valid narrow", {11'h0, vt8}, {11'h0, v8});
    check("data narrow", {8'h0, data8}, {8'h0, d8});
    check("valid wide", {11'h0, vt12}, {11'h0, v12});
    check("data wide", {8'h0, data12}, 12'h0);
  endtask : outs

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    outs(1'b0, 4'h0, 1'b0);
    check("osc idle", {11'h0, osc8}, 12'h0);
    check("osc wide idle", {11'h0, osc12}, 12'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_three;
    enc.send_word(12'h5a3, 12);
    check("osc awake", {11'h0, osc8}, 12'h1);
    outs(1'b0, 4'h0, 1'b0);
    enc.send_word(12'h5a3, 30);
    outs(1'b0, 4'h0, 1'b0);
    enc.send_word(12'h5a3, 12);
    outs(1'b1, 4'h5, 1'b1);
    $display("test three done");
  endtask : t_three

  task automatic t_reload;
    enc.send_word(12'h6a3, 12);
    outs(1'b1, 4'h6, 1'b0);
    $display("test reload done");
  endtask : t_reload

  task automatic t_mismatch;
    enc.send_word(12'h6a2, 12);
    outs(1'b0, 4'h6, 1'b0);
    enc.send_word(12'h9a3, 12);
    enc.send_word(12'h9a3, 12);
    outs(1'b0, 4'h6, 1'b0);
    enc.send_word(12'h9a3, 12);
    outs(1'b1, 4'h9, 1'b0);
    $display("test mismatch done");
  endtask : t_mismatch

  task automatic t_silence;
    repeat (230) @(negedge clk);
    outs(1'b0, 4'h9, 1'b0);
    check("osc stop", {11'h0, osc8}, 12'h0);
    check("osc wide stop", {11'h0, osc12}, 12'h0);
    $display("test silence done");
  endtask : t_silence

  // new strap setting while in standby; both builds must follow it
  task automatic t_strap;
    @(negedge clk);
    addr_pins = 12'h3c7;
    enc.send_word(12'h3c7, 12);
    check("osc wide awake", {11'h0, osc12}, 12'h1);
    outs(1'b0, 4'h9, 1'b0);
    enc.send_word(12'h3c7, 12);
    outs(1'b0, 4'h9, 1'b0);
    enc.send_word(12'h3c7, 12);
    outs(1'b1, 4'h3, 1'b1);
    $display("test strap done");
  endtask : t_strap

  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_three();
    t_reload();
    t_mismatch();
    t_silence();
    t_strap();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule : remote_code_decoder_test
